// File: src/tsf_status_flags.sv
// status flag set/clear logic for two timers and the serial interface
// Overview of operation
// - timer flags: simultaneous set and clear leaves the flag set.
// - serial flags: simultaneous set and clear leaves the flag clear.
// - capture_flag sets on capture edge loading the counter; reset clears it.
// - capture_flag clears on status read while set, then capture_register_high read.
// - compare1_flag sets on match; clears on status read then compare1 write.
// - compare2_flag sets on match; clears only on alt status read then compare2 write.
// - compare match re-sets every matching cycle, overriding a pending clear.
// - overflow_flag sets cycle after counter hits ffff; timer1_status then counter_high clears.
// - match2_flag sets on timer2 match; writing zero while set clears it.
// - rx_full_flag sets on receive transfer; serial_status then rx_data read clears.
// - rx_error_flag sets in async mode only, on zero stop bit or overrun transfer.
// - rx_error_flag clears on serial_status then rx_data read, or reset.
// - tx_empty_flag sets on async load or sync shift empty; reset sets it.
// - tx_empty_flag clears on serial_status read then tx_data write; software enables first.
// - one serial_status read arms the clear of all set serial flags.
`timescale 1ns/1ps
module tsf_status_flags
   import tsf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [TSF_CNT_W-1:0] free_running_counter,
   input wire logic [TSF_CNT_W-1:0] compare1_register,
   input wire logic [TSF_CNT_W-1:0] compare2_register,
   input wire logic [TSF_T2_W-1:0] timer2_counter,
   input wire logic [TSF_T2_W-1:0] timer2_constant,
   input wire tsf_event_t events,
   input wire tsf_access_t access,
   output tsf_flags_t flags
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // timer style: set wins
   function automatic logic tsf_set_wins(input logic q, input logic set, input logic clr);
      tsf_set_wins = set | (q & ~clr);
   endfunction : tsf_set_wins

   // serial style: clear wins
   function automatic logic tsf_clr_wins(input logic q, input logic set, input logic clr);
      tsf_clr_wins = ~clr & (set | q);
   endfunction : tsf_clr_wins

   // arm holds until the data access; a later status read re-evaluates it
   function automatic logic tsf_arm(input logic arm_q, input logic rd, input logic flag_q,
                                    input logic done);
      if (rd) begin
         tsf_arm = flag_q;
      end else if (done) begin
         tsf_arm = 1'b0;
      end else begin
         tsf_arm = arm_q & flag_q;
      end
   endfunction : tsf_arm

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   tsf_state_t state_q;
   tsf_state_t state_d;

   logic rd_t1_any;
   logic cmp1_hit;
   logic cmp2_hit;
   logic clr_cap;
   logic clr_cmp1;
   logic clr_cmp2;
   logic clr_ovf;
   logic clr_m2;
   logic clr_rx;
   logic clr_tx;
   logic set_err;
   logic set_tx;

   always_comb begin
      state_d = state_q;
      rd_t1_any = access.rd_timer1_status | access.rd_timer1_status_alt;
      // comparators are level tests, so a held match keeps re-setting
      cmp1_hit = (compare1_register == free_running_counter);
      cmp2_hit = (compare2_register == free_running_counter);

      // the completing access must follow an earlier armed read, not the same cycle; match2 clears on the zero write alone
      clr_cap = state_q.arm.capture & access.rd_capture_high;
      clr_cmp1 = state_q.arm.compare1 & access.wr_compare1;
      clr_cmp2 = state_q.arm.compare2 & access.wr_compare2;
      clr_ovf = state_q.arm.overflow & access.rd_counter_high;
      clr_m2 = access.wr_match2_zero & state_q.flags.match2_flag;
      clr_rx = state_q.arm.rx & access.rd_rx_data;
      clr_tx = state_q.arm.tx & access.wr_tx_data;

      // overflow lands one cycle after the counter sits at top
      state_d.counter_top = (free_running_counter == TSF_CNT_TOP);

      state_d.flags.capture_flag = tsf_set_wins(state_q.flags.capture_flag, events.capture_edge,
                                                clr_cap);
      state_d.flags.compare1_flag = tsf_set_wins(state_q.flags.compare1_flag, cmp1_hit,
                                                 clr_cmp1);
      state_d.flags.compare2_flag = tsf_set_wins(state_q.flags.compare2_flag, cmp2_hit,
                                                 clr_cmp2);
      state_d.flags.overflow_flag = tsf_set_wins(state_q.flags.overflow_flag, state_q.counter_top,
                                                 clr_ovf);
      state_d.flags.match2_flag = tsf_set_wins(state_q.flags.match2_flag,
                                               timer2_counter == timer2_constant, clr_m2);

      // overrun sees the full flag as it stood before this transfer
      set_err = (events.async_mode & events.stop_bit_zero)
              | (events.async_mode & events.rx_transfer & state_q.flags.rx_full_flag);
      set_tx = events.async_mode ? events.tx_load : events.tx_shift_empty;

      state_d.flags.rx_full_flag = tsf_clr_wins(state_q.flags.rx_full_flag, events.rx_transfer,
                                                clr_rx);
      state_d.flags.rx_error_flag = tsf_clr_wins(state_q.flags.rx_error_flag, set_err,
                                                 clr_rx & state_q.arm.rx);
      state_d.flags.tx_empty_flag = tsf_clr_wins(state_q.flags.tx_empty_flag, set_tx,
                                                 clr_tx);

      // arming
      state_d.arm.capture = tsf_arm(state_q.arm.capture, rd_t1_any,
                                    state_q.flags.capture_flag, clr_cap);
      state_d.arm.compare1 = tsf_arm(state_q.arm.compare1, rd_t1_any,
                                     state_q.flags.compare1_flag, clr_cmp1);
      state_d.arm.compare2 = tsf_arm(state_q.arm.compare2, access.rd_timer1_status_alt,
                                     state_q.flags.compare2_flag, clr_cmp2);
      state_d.arm.overflow = tsf_arm(state_q.arm.overflow, access.rd_timer1_status,
                                     state_q.flags.overflow_flag, clr_ovf);
      // one status read covers receive-full and receive-error together
      state_d.arm.rx = tsf_arm(state_q.arm.rx, access.rd_serial_status,
                               state_q.flags.rx_full_flag | state_q.flags.rx_error_flag,
                               clr_rx);
      state_d.arm.tx = tsf_arm(state_q.arm.tx, access.rd_serial_status,
                               state_q.flags.tx_empty_flag, clr_tx);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q.flags <= TSF_FLAGS_RST;
         state_q.arm <= '0;
         state_q.counter_top <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign flags = state_q.flags;

endmodule : tsf_status_flags

// File: pkg/tsf_pkg.sv
// package for the timer and serial status flag bank
package tsf_pkg;
   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int unsigned TSF_CNT_W = 16;
   localparam int unsigned TSF_T2_W = 8;
   localparam logic [TSF_CNT_W-1:0] TSF_CNT_TOP = 16'hffff;
   localparam logic TSF_TIMER_FLAG_RST = 1'b0;
   localparam logic TSF_RX_FLAG_RST = 1'b0;
   localparam logic TSF_TX_EMPTY_RST = 1'b1;

   // ----------------------------------------------------------------
   // bus access strobes, one-cycle pulses
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rd_timer1_status;
      logic rd_timer1_status_alt;
      logic rd_capture_high;
      logic wr_compare1;
      logic wr_compare2;
      logic rd_counter_high;
      logic wr_match2_zero;
      logic rd_serial_status;
      logic rd_rx_data;
      logic wr_tx_data;
   } tsf_access_t;

   // ----------------------------------------------------------------
   // hardware events
   // ----------------------------------------------------------------
   typedef struct packed {
      logic capture_edge;
      logic rx_transfer;
      logic stop_bit_zero;
      logic tx_load;
      logic tx_shift_empty;
      logic async_mode;
   } tsf_event_t;

   typedef struct packed {
      logic capture_flag;
      logic compare1_flag;
      logic compare2_flag;
      logic overflow_flag;
      logic match2_flag;
      logic rx_full_flag;
      logic rx_error_flag;
      logic tx_empty_flag;
   } tsf_flags_t;

   // armed clear sequences
   typedef struct packed {
      logic capture;
      logic compare1;
      logic compare2;
      logic overflow;
      logic rx;
      logic tx;
   } tsf_arm_t;

   typedef struct packed {
      tsf_flags_t flags;
      tsf_arm_t arm;
      logic counter_top;
   } tsf_state_t;

   localparam tsf_flags_t TSF_FLAGS_RST = '{
      capture_flag: TSF_TIMER_FLAG_RST, compare1_flag: TSF_TIMER_FLAG_RST,
      compare2_flag: TSF_TIMER_FLAG_RST, overflow_flag: TSF_TIMER_FLAG_RST,
      match2_flag: TSF_TIMER_FLAG_RST, rx_full_flag: TSF_RX_FLAG_RST,
      rx_error_flag: TSF_RX_FLAG_RST, tx_empty_flag: TSF_TX_EMPTY_RST};
endpackage : tsf_pkg

// File: testbench/tsf_status_flags_assertions.sv
// concurrent checks on the status flag bank ports
`timescale 1ns/1ps
module tsf_status_flags_chk
   import tsf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [TSF_CNT_W-1:0] free_running_counter,
   input wire logic [TSF_CNT_W-1:0] compare1_register,
   input wire logic [TSF_CNT_W-1:0] compare2_register,
   input wire logic [TSF_T2_W-1:0] timer2_counter,
   input wire logic [TSF_T2_W-1:0] timer2_constant,
   input wire tsf_event_t events,
   input wire tsf_access_t access,
   input wire tsf_flags_t flags
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_cap_set: assert property (events.capture_edge |=> flags.capture_flag) else $error("capture not set");
   a_cmp1_set: assert property (compare1_register == free_running_counter |=> flags.compare1_flag)
      else $error("compare1 not set");
   a_cmp2_set: assert property (compare2_register == free_running_counter |=> flags.compare2_flag)
      else $error("compare2 not set");
   a_ovf_set: assert property (free_running_counter == TSF_CNT_TOP |-> ##2 flags.overflow_flag)
      else $error("overflow not set");
   a_match2_set: assert property (timer2_counter == timer2_constant |=> flags.match2_flag)
      else $error("match2 not set");
   a_tx_reset: assert property ($rose(rst_n) |-> flags.tx_empty_flag) else $error("tx empty low after reset");
   a_cap_hold: assert property (flags.capture_flag && !access.rd_capture_high |=> flags.capture_flag)
      else $error("capture dropped");
   a_rx_clear: assert property (access.rd_serial_status && flags.rx_full_flag ##[1:2] access.rd_rx_data
      |=> !flags.rx_full_flag && !flags.rx_error_flag) else $error("rx flags not cleared");
   a_tx_clear: assert property (access.rd_serial_status && flags.tx_empty_flag ##[1:2] access.wr_tx_data
      |=> !flags.tx_empty_flag) else $error("tx empty not cleared");
endmodule : tsf_status_flags_chk

// File: testbench/tb_tsf_status_flags.sv
// self-checking bench for the status flag bank
`timescale 1ns/1ps
module tb_tsf_status_flags;
   import tsf_pkg::*;
   // access strobes and event pulses, one bit each
   localparam tsf_access_t S1 = 10'h200, S2 = 10'h100, CH = 10'h080, W1 = 10'h040, W2 = 10'h020;
   localparam tsf_access_t FH = 10'h010, MZ = 10'h008, SS = 10'h004, RR = 10'h002, WT = 10'h001;
   localparam tsf_event_t N0 = 6'h00, CE = 6'h20, RX = 6'h10, SB = 6'h08, TL = 6'h04, TS = 6'h02;
   logic sys_clk = 1'b0;
   logic rst_n;
   logic [15:0] free_running_counter, compare1_register, compare2_register;
   logic [7:0] timer2_counter, timer2_constant;
   tsf_event_t events;
   tsf_access_t access;
   tsf_flags_t flags;
   logic am = 1'b0;
   int num_errors = 0;
   int comparisons = 0;
   always #2.5 sys_clk = ~sys_clk;
   tsf_status_flags dut (.sys_clk(sys_clk), .rst_n(rst_n), .free_running_counter(free_running_counter),
      .compare1_register(compare1_register), .compare2_register(compare2_register),
      .timer2_counter(timer2_counter), .timer2_constant(timer2_constant), .events(events),
      .access(access), .flags(flags));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   // one-cycle pulse; returns just after the edge that samples it
   task automatic drv(input tsf_access_t a, input tsf_event_t e);
      @(posedge sys_clk);
      e.async_mode = am;
      access <= a;
      events <= e;
      @(posedge sys_clk);
      e = '0;
      e.async_mode = am;
      access <= '0;
      events <= e;
      #1;
   endtask : drv
   task automatic chk(input logic g, input logic x);
      comparisons++;
      if (g !== x) begin
         num_errors++;
         $display("ERROR t=%0t flag got %b want %b", $time, g, x);
      end
   endtask : chk
   task end_of_test;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_cap;
      drv('0, CE);
      chk(flags.capture_flag, 1'b1);
      drv(CH, N0);
      chk(flags.capture_flag, 1'b1);
      drv(S2, N0);
      drv(S1, CE);
      drv(CH, CE);
      chk(flags.capture_flag, 1'b1);
      drv(S1, N0);
      drv(CH, N0);
      chk(flags.capture_flag, 1'b0);
      $display("capture test done");
   endtask : t_cap
   task t_cmp;
      @(posedge sys_clk);
      compare1_register <= 16'h0010;
      compare2_register <= 16'h0010;
      drv(S2, N0);
      drv(W1 | W2, N0);
      chk(flags.compare1_flag, 1'b1);
      chk(flags.compare2_flag, 1'b1);
      @(posedge sys_clk);
      compare1_register <= 16'h0100;
      compare2_register <= 16'h0200;
      drv(S1, N0);
      drv(W1 | W2, N0);
      chk(flags.compare1_flag, 1'b0);
      chk(flags.compare2_flag, 1'b1);
      drv(S2, N0);
      drv(W2, N0);
      chk(flags.compare2_flag, 1'b0);
      $display("compare test done");
   endtask : t_cmp
   task t_ovf;
      @(posedge sys_clk);
      free_running_counter <= TSF_CNT_TOP;
      @(posedge sys_clk);
      free_running_counter <= 16'h0010;
      #1;
      chk(flags.overflow_flag, 1'b0);
      @(posedge sys_clk);
      #1;
      chk(flags.overflow_flag, 1'b1);
      drv(S2, N0);
      drv(FH, N0);
      chk(flags.overflow_flag, 1'b1);
      drv(S1, N0);
      drv(FH, N0);
      chk(flags.overflow_flag, 1'b0);
      $display("overflow test done");
   endtask : t_ovf
   task t_m2;
      @(posedge sys_clk);
      timer2_counter <= 8'h80;
      drv(MZ, N0);
      chk(flags.match2_flag, 1'b1);
      @(posedge sys_clk);
      timer2_counter <= 8'h01;
      drv(MZ, N0);
      chk(flags.match2_flag, 1'b0);
      $display("match2 test done");
   endtask : t_m2
   task t_ser;
      drv('0, SB);
      chk(flags.rx_error_flag, 1'b0);
      am = 1'b1;
      drv('0, RX);
      chk(flags.rx_full_flag, 1'b1);
      drv('0, RX);
      chk(flags.rx_error_flag, 1'b1);
      drv(SS, N0);
      drv(RR, N0);
      chk(flags.rx_full_flag | flags.rx_error_flag, 1'b0);
      drv(WT, N0);
      chk(flags.tx_empty_flag, 1'b0);
      drv('0, SB | TL);
      chk(flags.rx_error_flag & flags.tx_empty_flag, 1'b1);
      drv('0, RX);
      drv(SS, N0);
      drv(RR | WT, RX | TL);
      chk(flags.rx_full_flag | flags.rx_error_flag | flags.tx_empty_flag, 1'b0);
      am = 1'b0;
      drv('0, TS);
      chk(flags.tx_empty_flag, 1'b1);
      $display("serial test done");
   endtask : t_ser
   initial begin
      rst_n = 1'b0;
      free_running_counter = 16'h0010;
      compare1_register = 16'h0100;
      compare2_register = 16'h0200;
      timer2_counter = 8'h01;
      timer2_constant = 8'h80;
      events = '0;
      access = '0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk(flags === TSF_FLAGS_RST, 1'b1);
      t_cap;
      t_cmp;
      t_ovf;
      t_m2;
      t_ser;
      end_of_test;
   end
   // tests need about 80 cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      num_errors++;
      end_of_test;
   end
endmodule : tb_tsf_status_flags
bind tsf_status_flags tsf_status_flags_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .free_running_counter(free_running_counter), .compare1_register(compare1_register),
   .compare2_register(compare2_register), .timer2_counter(timer2_counter),
   .timer2_constant(timer2_constant), .events(events), .access(access), .flags(flags));
